// [rscr_host.sv]
`timescale 1ns/1ps
// host side of the command-code port: one request per call, held for a full cycle
module rscr_host (
  input wire logic i_clk,
  output rscr_pkg::rscr_reg_req_t o_req
);
  import rscr_pkg::*;
  initial o_req = '0;
  // wr is a one-cycle pulse; the code stays so the registered read answers it
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wdata);
    @(posedge i_clk);
    o_req <= '{wr, code, wdata};
    @(posedge i_clk);
    o_req <= '{1'b0, code, 8'h00};
  endtask
endmodule // rscr_host

// [rscr_pkg.sv]
// Operation
// - latch enable set: timeout expires, output latches off
// - latch enable clear in both: never latch off
// - second config copy; both-gated functions need both
// - delay code sets phases 1,3,5; latchoff 4x
// - soft-start slew code sets ramp of phases 2,4
// - dynamic voltage slew: 1 V/ms plus 2 per step
// - read-only 16-bit aux sense readback
// - aux sense selectable: pin, input voltage, input current
// - readbacks use linear exponent/mantissa format
// - read-only 16-bit termination rail readback
package rscr_pkg;
  localparam logic [7:0] CODE_CFG_B = 8'h00_D3;
  localparam logic [7:0] CODE_DELAY = 8'h00_D4;
  localparam logic [7:0] CODE_RISE = 8'h00_D5;
  localparam logic [7:0] CODE_DVID = 8'h00_D6;
  localparam logic [7:0] CODE_AUX = 8'h00_D7;
  localparam logic [7:0] CODE_TERM = 8'h00_D8;

  localparam logic [7:0] RST_CFG_B = 8'h00_52;
  localparam logic [7:0] RST_DELAY = 8'h00_03;
  localparam logic [7:0] RST_RISE = 8'h00_02;
  localparam logic [7:0] RST_DVID = 8'h00_01;
  localparam logic [15:0] RST_READBACK = 16'h0000;

  localparam int CLIM_BIT = 1;
  localparam int LOOP_BIT = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'h00_FE;
  localparam logic [7:0] CODE3_MASK = 8'h00_07;
  localparam int LATCH_MULT = 4;
  // default delay step of one code unit, in microseconds
  localparam int DELAY_STEP_US = 1000;
  localparam int CLK_MHZ = 100;

  typedef struct packed {
    logic wr;
    logic [7:0] code;
    logic [7:0] wdata;
  } rscr_reg_req_t;

  typedef struct packed {
    logic [4:0] exponent;
    logic [10:0] mantissa;
  } rscr_linear_t;

  typedef enum logic [1:0] {
    AUX_PIN = 2'h0,
    AUX_VIN = 2'h1,
    AUX_IIN = 2'h2
  } rscr_aux_sel_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_PH1 = 7'b000_0010,
    ST_PH2 = 7'b000_0100,
    ST_PH3 = 7'b000_1000,
    ST_PH4 = 7'b001_0000,
    ST_PH5 = 7'b010_0000,
    ST_DONE = 7'b100_0000
  } rscr_state_t;
endpackage

// [rscr_regs.sv]
`timescale 1ns/1ps
module rscr_regs #(
  parameter int DELAY_STEP_CYCLES = rscr_pkg::DELAY_STEP_US * rscr_pkg::CLK_MHZ,
  parameter logic [4:0] LIN_EXPONENT = 5'h18
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire rscr_pkg::rscr_reg_req_t I_REG_REQ,
  output logic [15:0] O_REG_RDATA,
  output logic O_REG_HIT,
  input wire logic [7:0] I_CFG_COPY_A,
  input wire logic I_ENABLE,
  input wire logic I_CURRENT_LIMIT,
  input wire logic I_RAMP_DONE,
  input wire rscr_pkg::rscr_aux_sel_t I_AUX_SEL,
  input wire logic I_ADC_VALID,
  input wire logic [10:0] I_AUX_ADC,
  input wire logic [10:0] I_TERM_ADC,
  output rscr_pkg::rscr_aux_sel_t O_AUX_SEL,
  output logic O_LATCHOFF,
  output logic O_LOOP_TEST_EN,
  output rscr_pkg::rscr_state_t O_STARTUP_PHASE,
  output logic O_RAMP_ACTIVE,
  output logic [4:0] O_RAMP_RATE_TENTHS,
  output logic [4:0] O_DVID_RATE_VMS
);
  import rscr_pkg::*;

  // the latchoff count is 32 bits wide: eight steps times four must not overflow it
  if (DELAY_STEP_CYCLES < 1 || DELAY_STEP_CYCLES > 1000000) begin : g_step_check
    $error("DELAY_STEP_CYCLES out of range");
  end

  logic [7:0] cfg_b_ff;
  logic [7:0] delay_ff;
  logic [7:0] rise_ff;
  logic [7:0] dvid_ff;
  rscr_linear_t aux_ff;
  rscr_linear_t term_ff;
  logic cl_meta_ff;
  logic cl_sync_ff;
  logic en_meta_ff;
  logic en_sync_ff;
  logic [31:0] lt_cnt_ff;
  logic latch_ff;
  logic [31:0] ph_cnt_ff;
  rscr_state_t st_ff;
  rscr_state_t nxt_st;
  rscr_aux_sel_t aux_sel_ff;

  wire wr_b = I_REG_REQ.wr && I_REG_REQ.code == CODE_CFG_B;
  wire wr_delay = I_REG_REQ.wr && I_REG_REQ.code == CODE_DELAY;
  wire wr_rise = I_REG_REQ.wr && I_REG_REQ.code == CODE_RISE;
  wire wr_dvid = I_REG_REQ.wr && I_REG_REQ.code == CODE_DVID;

  // latch enable is an or of both copies: clear in both disables it
  wire latch_en = I_CFG_COPY_A[CLIM_BIT] | cfg_b_ff[CLIM_BIT];
  assign O_LOOP_TEST_EN = I_CFG_COPY_A[LOOP_BIT] & cfg_b_ff[LOOP_BIT];

  wire [31:0] delay_cyc = 32'(({29'd0, delay_ff[2:0]} + 32'd1) * DELAY_STEP_CYCLES);
  wire [31:0] latch_cyc = 32'(delay_cyc * LATCH_MULT);
  wire lt_expire = en_sync_ff && cl_sync_ff && latch_en && lt_cnt_ff >= latch_cyc - 32'd1;
  wire ph_expire = ph_cnt_ff >= delay_cyc - 32'd1;

  assign O_RAMP_RATE_TENTHS = {1'b0, rise_ff[2:0], 1'b1};
  assign O_DVID_RATE_VMS = {1'b0, dvid_ff[2:0], 1'b1};
  assign O_LATCHOFF = latch_ff;
  assign O_STARTUP_PHASE = st_ff;
  assign O_RAMP_ACTIVE = st_ff == ST_PH2 || st_ff == ST_PH4;
  assign O_AUX_SEL = aux_sel_ff;

  // register writes; reserved bit 0 is never stored
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      cfg_b_ff <= RST_CFG_B;
      delay_ff <= RST_DELAY;
      rise_ff <= RST_RISE;
      dvid_ff <= RST_DVID;
    end else begin
      if (wr_b) cfg_b_ff <= I_REG_REQ.wdata & CFG_WR_MASK;
      if (wr_delay) delay_ff <= I_REG_REQ.wdata & CODE3_MASK;
      if (wr_rise) rise_ff <= I_REG_REQ.wdata & CODE3_MASK;
      if (wr_dvid) dvid_ff <= I_REG_REQ.wdata & CODE3_MASK;
    end
  end

  // readbacks only move on a converter sample, never on a host write
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      aux_ff <= RST_READBACK;
      term_ff <= RST_READBACK;
      aux_sel_ff <= AUX_PIN;
    end else begin
      aux_sel_ff <= I_AUX_SEL;
      if (I_ADC_VALID) begin
        aux_ff <= {LIN_EXPONENT, I_AUX_ADC};
        term_ff <= {LIN_EXPONENT, I_TERM_ADC};
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_REG_RDATA <= 16'h0000;
      O_REG_HIT <= 1'b0;
    end else begin
      O_REG_HIT <= 1'b1;
      unique case (I_REG_REQ.code)
        CODE_CFG_B: O_REG_RDATA <= {8'h00, cfg_b_ff};
        CODE_DELAY: O_REG_RDATA <= {8'h00, delay_ff};
        CODE_RISE: O_REG_RDATA <= {8'h00, rise_ff};
        CODE_DVID: O_REG_RDATA <= {8'h00, dvid_ff};
        CODE_AUX: O_REG_RDATA <= aux_ff;
        CODE_TERM: O_REG_RDATA <= term_ff;
        default: begin
          O_REG_RDATA <= 16'h0000;
          O_REG_HIT <= 1'b0;
        end
      endcase
    end
  end

  // pin inputs cross through two flops before use
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      cl_meta_ff <= 1'b0;
      cl_sync_ff <= 1'b0;
      en_meta_ff <= 1'b0;
      en_sync_ff <= 1'b0;
    end else begin
      cl_meta_ff <= I_CURRENT_LIMIT;
      cl_sync_ff <= cl_meta_ff;
      en_meta_ff <= I_ENABLE;
      en_sync_ff <= en_meta_ff;
    end
  end

  // timer runs only while enabled and limited, so enabling never latches at once
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      lt_cnt_ff <= 32'd0;
      latch_ff <= 1'b0;
    end else begin
      if (!en_sync_ff || !cl_sync_ff || !latch_en || latch_ff) lt_cnt_ff <= 32'd0;
      else lt_cnt_ff <= lt_cnt_ff + 32'd1;
      if (!en_sync_ff) latch_ff <= 1'b0;
      else if (lt_expire) latch_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (en_sync_ff) nxt_st = ST_PH1;
      ST_PH1: if (ph_expire) nxt_st = ST_PH2;
      ST_PH2: if (I_RAMP_DONE) nxt_st = ST_PH3;
      ST_PH3: if (ph_expire) nxt_st = ST_PH4;
      ST_PH4: if (I_RAMP_DONE) nxt_st = ST_PH5;
      ST_PH5: if (ph_expire) nxt_st = ST_DONE;
      ST_DONE: nxt_st = ST_DONE;
      default: nxt_st = ST_IDLE;
    endcase
    if (!en_sync_ff || latch_ff) nxt_st = ST_IDLE;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_ff <= ST_IDLE;
      ph_cnt_ff <= 32'd0;
    end else begin
      st_ff <= nxt_st;
      ph_cnt_ff <= (nxt_st != st_ff) ? 32'd0 : ph_cnt_ff + 32'd1;
    end
  end

  sequence s_limit_hold;
    cl_sync_ff && latch_en && !latch_ff;
  endsequence

  property p_latch_on_expire;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (s_limit_hold and lt_expire and en_sync_ff) |=> latch_ff;
  endproperty
  a_latch_on_expire: assert property (p_latch_on_expire) else $error("no latchoff");

  property p_no_latch_disabled;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (!I_CFG_COPY_A[CLIM_BIT] && !cfg_b_ff[CLIM_BIT] && !latch_ff) |=> !latch_ff;
  endproperty
  a_no_latch_disabled: assert property (p_no_latch_disabled) else $error("latched");

  property p_loop_both;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_LOOP_TEST_EN |-> (I_CFG_COPY_A[LOOP_BIT] && cfg_b_ff[LOOP_BIT]);
  endproperty
  a_loop_both: assert property (p_loop_both) else $error("loop gate wrong");

  property p_latch_time;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      ($rose(latch_ff) && en_sync_ff) |-> $past(lt_cnt_ff) == latch_cyc - 32'd1;
  endproperty
  a_latch_time: assert property (p_latch_time) else $error("latch time wrong");

  property p_ramp_rate;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      wr_rise |=> O_RAMP_RATE_TENTHS == 5'(2 * $past(I_REG_REQ.wdata[2:0]) + 1);
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("ramp rate wrong");

  property p_dvid_rate;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      wr_dvid |=> O_DVID_RATE_VMS == 5'(2 * $past(I_REG_REQ.wdata[2:0]) + 1);
  endproperty
  a_dvid_rate: assert property (p_dvid_rate) else $error("dvid rate wrong");

  property p_aux_read;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_REG_REQ.code == CODE_AUX && !I_ADC_VALID) |=> O_REG_RDATA == aux_ff;
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux readback wrong");

  property p_linear;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      I_ADC_VALID |=> term_ff == {LIN_EXPONENT, $past(I_TERM_ADC)};
  endproperty
  a_linear: assert property (p_linear) else $error("linear format wrong");

  property p_ro_stable;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_REG_REQ.wr && !I_ADC_VALID) |=> $stable(aux_ff) && $stable(term_ff);
  endproperty
  a_ro_stable: assert property (p_ro_stable) else $error("readback written");

  property p_reserved_zero;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      I_REG_REQ.code == CODE_CFG_B |=> !O_REG_RDATA[0];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // startup steps: a timed phase, a ramp phase and the request to start
  sequence s_timed_phase;
    (st_ff == ST_PH1 || st_ff == ST_PH3 || st_ff == ST_PH5) && en_sync_ff && !latch_ff;
  endsequence

  sequence s_ramp_phase;
    O_RAMP_ACTIVE && en_sync_ff && !latch_ff;
  endsequence

  sequence s_start_req;
    st_ff == ST_IDLE && en_sync_ff && !latch_ff;
  endsequence

  property p_start_entry;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      s_start_req |=> (st_ff == ST_PH1 && ph_cnt_ff == 32'd0);
  endproperty
  a_start_entry: assert property (p_start_entry) else $error("startup not entered");

  property p_timed_stay;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (s_timed_phase and !ph_expire) |=> $stable(st_ff);
  endproperty
  a_timed_stay: assert property (p_timed_stay) else $error("timed phase cut short");

  property p_timed_exit;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (s_timed_phase and ph_expire) |=> (st_ff == ST_PH2 || st_ff == ST_PH4 || st_ff == ST_DONE);
  endproperty
  a_timed_exit: assert property (p_timed_exit) else $error("timed phase overrun");

  property p_ramp_wait;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (s_ramp_phase and !I_RAMP_DONE) |=> $stable(st_ff);
  endproperty
  a_ramp_wait: assert property (p_ramp_wait) else $error("ramp left early");

  property p_ramp_exit;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (s_ramp_phase and I_RAMP_DONE) |=> (st_ff == ST_PH3 || st_ff == ST_PH5);
  endproperty
  a_ramp_exit: assert property (p_ramp_exit) else $error("ramp not ended");

  property p_abort_idle;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (!en_sync_ff || latch_ff) |=> st_ff == ST_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("output not stopped");

  property p_latch_hold;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (latch_ff && en_sync_ff) |=> latch_ff;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latchoff released");

  property p_aux_sel;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      1'b1 |=> O_AUX_SEL == $past(I_AUX_SEL);
  endproperty
  a_aux_sel: assert property (p_aux_sel) else $error("aux source wrong");

  property p_term_read;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_REG_REQ.code == CODE_TERM && !I_ADC_VALID) |=> O_REG_RDATA == term_ff;
  endproperty
  a_term_read: assert property (p_term_read) else $error("term readback wrong");
endmodule // rscr_regs

// [test_regulator_sequencing_config_regs.sv]
`timescale 1ns/1ps
module test_regulator_sequencing_config_regs;
  import rscr_pkg::*;
  logic clk = 0, rst = 1, en = 0, lim = 0, rdone = 0, vld = 0, hit, latch, loop_en, ramp;
  logic [7:0] cfg_a = 8'h0052, c, d;
  logic [10:0] aux = 0, term = 0;
  logic [15:0] rdata;
  logic [4:0] rise_rate, dvid_rate;
  rscr_aux_sel_t sel = AUX_PIN, sel_out;
  rscr_state_t phase;
  rscr_reg_req_t req;
  int fail_count = 0, total_checks = 0, seed = 32'h73c7d7d1;
  int mdl [4] = '{82, 3, 2, 1};

  rscr_regs #(.DELAY_STEP_CYCLES(4), .LIN_EXPONENT(5'h18)) rscr_regs_inst (.I_CLK_SYS(clk),
    .I_RST(rst),
    .I_REG_REQ(req), .O_REG_RDATA(rdata), .O_REG_HIT(hit), .I_CFG_COPY_A(cfg_a),
    .I_ENABLE(en), .I_CURRENT_LIMIT(lim), .I_RAMP_DONE(rdone), .I_AUX_SEL(sel),
    .I_ADC_VALID(vld), .I_AUX_ADC(aux), .I_TERM_ADC(term), .O_AUX_SEL(sel_out),
    .O_LATCHOFF(latch), .O_LOOP_TEST_EN(loop_en), .O_STARTUP_PHASE(phase),
    .O_RAMP_ACTIVE(ramp), .O_RAMP_RATE_TENTHS(rise_rate), .O_DVID_RATE_VMS(dvid_rate));
  rscr_host rscr_host_inst (.i_clk(clk), .o_req(req));

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic exph);
    rscr_host_inst.xfer(1'b0, code, 8'h00);
    #1;
    chk(rdata, exp);
    chk({15'h0000, hit}, {15'h0000, exph});
  endtask

  // waits for a phase, then counts the cycles that it lasts
  task automatic phase_time(input rscr_state_t st, input int exp);
    int n;
    n = 0;
    #1;
    while (phase !== st && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (phase === st && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(exp));
  endtask

  task automatic pulse_ramp_done;
    @(posedge clk);
    rdone <= 1'b1;
    @(posedge clk);
    rdone <= 1'b0;
  endtask

  task automatic final_report;
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    final_report;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(CODE_CFG_B + i), i < 4 ? 16'(mdl[i]) : 16'h0000, 1'b1);
    // random codes reach past the map so read-only and unknown places get writes too
    repeat (24) begin
      c = 8'hD3 + 8'($random(seed) & 7);
      d = 8'($random(seed));
      rscr_host_inst.xfer(1'b1, c, d);
      if (c < 8'hD7) mdl[c - 8'hD3] = (c == 8'hD3) ? (d & 8'hFE) : (d & 8'h07);
      rd(c, c < 8'hD7 ? 16'(mdl[c - 8'hD3]) : 16'h0000, c < 8'hD9);
    end
    for (int i = 0; i < 8; i++) begin
      rscr_host_inst.xfer(1'b1, CODE_RISE, 8'(i));
      rscr_host_inst.xfer(1'b1, CODE_DVID, 8'(i));
      #1;
      chk(16'(rise_rate), 16'(2 * i + 1));
      chk(16'(dvid_rate), 16'(2 * i + 1));
    end
    @(posedge clk);
    aux <= 11'($random(seed));
    term <= 11'($random(seed));
    sel <= AUX_IIN;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    rscr_host_inst.xfer(1'b1, CODE_AUX, 8'hFF);
    rd(CODE_AUX, {5'h18, aux}, 1'b1);
    rd(CODE_TERM, {5'h18, term}, 1'b1);
    chk(16'(sel_out), 16'(AUX_IIN));
    // loop test needs bit 2 in both copies; ends with latch enable clear in both
    for (int i = 0; i < 4; i++) begin
      rscr_host_inst.xfer(1'b1, CODE_CFG_B, i[0] ? 8'h04 : 8'h00);
      cfg_a <= i[1] ? 8'h04 : 8'h00;
      @(posedge clk);
      #1;
      chk({15'h0000, loop_en}, {15'h0000, i == 3});
    end
    en <= 1'b1;
    lim <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0000, latch}, 16'h0000);
    lim <= 1'b0;
    rscr_host_inst.xfer(1'b1, CODE_DELAY, 8'h00);
    rscr_host_inst.xfer(1'b1, CODE_CFG_B, 8'h02);
    lim <= 1'b1;
    // code 0 with a step of 4 cycles gives a timeout of 16 cycles plus sync
    repeat (12) @(posedge clk);
    #1;
    chk({15'h0000, latch}, 16'h0000);
    repeat (20) @(posedge clk);
    #1;
    chk({15'h0000, latch}, 16'h0001);
    en <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({15'h0000, latch}, 16'h0000);
    // startup with a random delay code: each timed phase lasts code plus one steps
    d = 8'($random(seed)) & 8'h07;
    rscr_host_inst.xfer(1'b1, CODE_DELAY, d);
    lim <= 1'b0;
    en <= 1'b1;
    phase_time(ST_PH1, (d + 1) * 4);
    chk({15'h0000, ramp}, 16'h0001);
    pulse_ramp_done;
    phase_time(ST_PH3, (d + 1) * 4);
    chk({15'h0000, ramp}, 16'h0001);
    pulse_ramp_done;
    phase_time(ST_PH5, (d + 1) * 4);
    chk(16'(phase), 16'(ST_DONE));
    chk({15'h0000, ramp}, 16'h0000);
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(phase), 16'(ST_IDLE));
    // a reset in mid-run brings every register back to its default
    @(posedge clk);
    rst <= 1'b1;
    sel <= AUX_VIN;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mdl = '{82, 3, 2, 1};
    for (int i = 0; i < 6; i++) rd(8'(CODE_CFG_B + i), i < 4 ? 16'(mdl[i]) : 16'h0000, 1'b1);
    chk(16'(sel_out), 16'(AUX_VIN));
    chk({15'h0000, latch}, 16'h0000);
    final_report;
  end
endmodule // test_regulator_sequencing_config_regs
